// [rwk_consts.svh]
`ifndef RWK_CONSTS_SVH
`define RWK_CONSTS_SVH

// register addresses on the core's special-function bus
`define RWK_ADDR_CONFIG 8'ha1
`define RWK_ADDR_SUBSEC 8'ha2
`define RWK_ADDR_SEC 8'ha3
`define RWK_ADDR_MIN 8'ha4
`define RWK_ADDR_HOUR 8'ha5
`define RWK_ADDR_ALARM_INTERVAL_REGISTER 8'ha6
`define RWK_ADDR_KEY 8'hc1
`define RWK_ADDR_PINCFG 8'hff
`define RWK_ADDR_POWER 8'hc5

// unlock keys
`define RWK_KEY_POWER 8'ha7
`define RWK_KEY_TIME 8'hea

// pin configuration fields
`define RWK_PC_CAL_EN 7
`define RWK_PC_CAL_FREQ_SELECT_HI 6
`define RWK_PC_CAL_FREQ_SELECT_LO 5
`define RWK_PC_IRQB_HI 3
`define RWK_PC_IRQB_LO 1
`define RWK_PC_IRQA 0
`define RWK_PINCFG_RST 8'h00
`define RWK_KEY_RST 8'h00
`define RWK_POWER_RST 8'h00

// counter wrap points
`define RWK_SUBSEC_MAX 8'd127
`define RWK_SEC_MAX 8'd59
`define RWK_MIN_MAX 8'd59

// rtc clock: 32768 Hz; terminal counts, one less than the 32.768 kHz ticks per cal output half period or per full 128 Hz step
`define RWK_RTC_HZ 32768
`define RWK_TICKS_PER_SUBSEC 8'd255
`define RWK_HALF_1HZ 16'd16383
`define RWK_HALF_512HZ 16'd31
`define RWK_HALF_500HZ 16'd32
`define RWK_HALF_16KHZ 16'd0
`define RWK_SLOW_DIV 8'd255

`endif

// [rwk_pkg.sv]
package rwk_pkg;
  typedef struct packed {
    logic cal_output_enable;
    logic [1:0] cal_freq_select;
    logic reserved;
    logic [2:0] ext_irq_b_pin_function;
    logic ext_irq_a_pin_function;
  } rwk_pincfg_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } rwk_wr_t;

  typedef enum logic [1:0] {
    RWK_LOCKED,
    RWK_POWER_OPEN,
    RWK_TIME_OPEN
  } rwk_lock_t;

  typedef enum logic [1:0] {
    RWK_IRQB_GPIO,
    RWK_IRQB_BATT,
    RWK_IRQB_OFF,
    RWK_IRQB_ON
  } rwk_irqb_t;
endpackage

// [rwk_slow_sync.sv]
`timescale 1ns/100ps
`include "rwk_consts.svh"
// carries a core-side byte into the 128 Hz update domain; the core holds the
// value steady and the transfer completes on the second 128 Hz edge
module rwk_slow_sync
  import rwk_pkg::*;
(
  // clocks
  input wire logic clk,
  input wire logic rst,
  input wire logic slow_tick,
  // data
  input wire logic [7:0] core_val,
  output logic [7:0] rtc_val
);
  logic [7:0] hold_r;

  // first 128 Hz edge latches, second publishes: worst case two periods
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_r <= 8'h00;
    end else if (slow_tick) begin
      hold_r <= core_val;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rtc_val <= 8'h00;
    end else if (slow_tick) begin
      rtc_val <= hold_r;
    end
  end
endmodule

// [rwk_top.sv]
// Functional notes
// - With the calibration enable bit 7 set, the selected calibration pulse drives the cal pin.
// - Irq A bit enables its input; irq B field picks gpio, battery control, off or on.
// - Power control writes are accepted only after key 0xa7 is loaded.
// - Pin configuration and timekeeping writes require key 0xea first.
// - Timekeeping counter writes are blocked unless the time key is held.
// - The timekeeping counters advance on the 32.768 kHz rtc tick.
// - Configuration and interval registers pass into the rtc on the 128 Hz tick.
// - Those writes reach the rtc within two 128 Hz periods.
// - The sub-second counter steps each 1/128 s, wraps 127 to 0 and carries into seconds.
`timescale 1ns/100ps
`include "rwk_consts.svh"
module rwk_top
  import rwk_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // 32.768 kHz crystal pulse, asynchronous to clk
  input wire logic rtc_xtal,
  // core register bus
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // external pins
  input wire logic ext_irq_a_in,
  input wire logic ext_irq_b_in,
  output logic shared_cal_pin,
  output logic shared_cal_pin_oe,
  output logic ext_irq_a_req,
  output logic ext_irq_b_req,
  output logic battery_control_input,
  output logic ext_irq_b_gpio_in,
  // values seen inside the rtc
  output logic [7:0] power_control_register,
  output logic [7:0] rtc_config_q,
  output logic [7:0] alarm_interval_q
);
  logic [2:0] xtal_sync_r;
  logic [1:0] irqa_sync_r;
  logic [1:0] irqb_sync_r;
  logic rtc_tick;
  logic [7:0] write_key_register;
  rwk_pincfg_t pincfg_r;
  rwk_lock_t lock;
  logic [7:0] rtc_config_register;
  logic [7:0] alarm_interval_register;
  logic [7:0] sub_second_counter;
  logic [7:0] sec_r;
  logic [7:0] min_r;
  logic [7:0] hour_r;
  logic [7:0] tick_cnt_r;
  logic [7:0] slow_cnt_r;
  logic slow_tick;
  logic [15:0] cal_cnt_r;
  logic [15:0] cal_half;
  logic cal_wave_r;
  logic subsec_wrap;
  rwk_irqb_t irqb_mode;

  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] b);
    wr_hit = wr && (a == b);
  endfunction

  function automatic logic is_time_reg(input logic [7:0] a);
    is_time_reg = (a == `RWK_ADDR_SUBSEC) || (a == `RWK_ADDR_SEC) ||
                  (a == `RWK_ADDR_MIN) || (a == `RWK_ADDR_HOUR) ||
                  (a == `RWK_ADDR_PINCFG);
  endfunction

  // pin synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xtal_sync_r <= 3'h0;
      irqa_sync_r <= 2'h0;
      irqb_sync_r <= 2'h0;
    end else begin
      xtal_sync_r <= {xtal_sync_r[1:0], rtc_xtal};
      irqa_sync_r <= {irqa_sync_r[0], ext_irq_a_in};
      irqb_sync_r <= {irqb_sync_r[0], ext_irq_b_in};
    end
  end

  assign rtc_tick = xtal_sync_r[1] && !xtal_sync_r[2];

  always_comb begin
    unique case (write_key_register)
      `RWK_KEY_POWER: lock = RWK_POWER_OPEN;
      `RWK_KEY_TIME: lock = RWK_TIME_OPEN;
      default: lock = RWK_LOCKED;
    endcase
  end

  // a protected write spends the key so runaway code cannot follow through
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_key_register <= `RWK_KEY_RST;
    end else if (wr_hit(sfr_wr, sfr_addr, `RWK_ADDR_KEY)) begin
      write_key_register <= sfr_wdata;
    end else if (sfr_wr && lock == RWK_TIME_OPEN && is_time_reg(sfr_addr)) begin
      write_key_register <= 8'h00;
    end else if (wr_hit(sfr_wr, sfr_addr, `RWK_ADDR_POWER) && lock == RWK_POWER_OPEN) begin
      write_key_register <= 8'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_control_register <= `RWK_POWER_RST;
    end else if (wr_hit(sfr_wr, sfr_addr, `RWK_ADDR_POWER) && lock == RWK_POWER_OPEN) begin
      power_control_register <= sfr_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pincfg_r <= `RWK_PINCFG_RST;
    end else if (wr_hit(sfr_wr, sfr_addr, `RWK_ADDR_PINCFG) && lock == RWK_TIME_OPEN) begin
      // bit 4 is reserved and always reads back as zero
      pincfg_r <= {sfr_wdata[7:5], 1'b0, sfr_wdata[3:0]};
    end
  end

  // config and interval are not key protected
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rtc_config_register <= 8'h00;
      alarm_interval_register <= 8'h00;
    end else begin
      if (wr_hit(sfr_wr, sfr_addr, `RWK_ADDR_CONFIG)) begin
        rtc_config_register <= sfr_wdata;
      end
      if (wr_hit(sfr_wr, sfr_addr, `RWK_ADDR_ALARM_INTERVAL_REGISTER)) begin
        alarm_interval_register <= sfr_wdata;
      end
    end
  end

  // 128 Hz tick: 256 crystal ticks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slow_cnt_r <= 8'h00;
    end else if (rtc_tick) begin
      slow_cnt_r <= (slow_cnt_r == `RWK_SLOW_DIV) ? 8'h00 : slow_cnt_r + 8'h01;
    end
  end
  assign slow_tick = rtc_tick && (slow_cnt_r == `RWK_SLOW_DIV);

  rwk_slow_sync u_cfg_sync (
    .clk(clk),
    .rst(rst),
    .slow_tick(slow_tick),
    .core_val(rtc_config_register),
    .rtc_val(rtc_config_q)
  );

  rwk_slow_sync u_alarm_interval_register_sync (
    .clk(clk),
    .rst(rst),
    .slow_tick(slow_tick),
    .core_val(alarm_interval_register),
    .rtc_val(alarm_interval_q)
  );

  // timekeeping counters step on the crystal tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 8'h00;
    end else if (rtc_tick) begin
      tick_cnt_r <= (tick_cnt_r == `RWK_TICKS_PER_SUBSEC) ? 8'h00 : tick_cnt_r + 8'h01;
    end
  end

  assign subsec_wrap = rtc_tick && (tick_cnt_r == `RWK_TICKS_PER_SUBSEC) &&
                       (sub_second_counter == `RWK_SUBSEC_MAX);

  // a protected write wins over the tick in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sub_second_counter <= 8'h00;
    end else if (wr_hit(sfr_wr, sfr_addr, `RWK_ADDR_SUBSEC) && lock == RWK_TIME_OPEN) begin
      sub_second_counter <= sfr_wdata;
    end else if (rtc_tick && tick_cnt_r == `RWK_TICKS_PER_SUBSEC) begin
      sub_second_counter <= subsec_wrap ? 8'h00 : sub_second_counter + 8'h01;
    end
  end

  // hours count freely to 255; 24 hour mode lives in the omitted cascade
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_r <= 8'h00;
      min_r <= 8'h00;
      hour_r <= 8'h00;
    end else begin
      if (wr_hit(sfr_wr, sfr_addr, `RWK_ADDR_SEC) && lock == RWK_TIME_OPEN) begin
        sec_r <= sfr_wdata;
      end else if (subsec_wrap) begin
        sec_r <= (sec_r == `RWK_SEC_MAX) ? 8'h00 : sec_r + 8'h01;
      end
      if (wr_hit(sfr_wr, sfr_addr, `RWK_ADDR_MIN) && lock == RWK_TIME_OPEN) begin
        min_r <= sfr_wdata;
      end else if (subsec_wrap && sec_r == `RWK_SEC_MAX) begin
        min_r <= (min_r == `RWK_MIN_MAX) ? 8'h00 : min_r + 8'h01;
      end
      if (wr_hit(sfr_wr, sfr_addr, `RWK_ADDR_HOUR) && lock == RWK_TIME_OPEN) begin
        hour_r <= sfr_wdata;
      end else if (subsec_wrap && sec_r == `RWK_SEC_MAX && min_r == `RWK_MIN_MAX) begin
        hour_r <= hour_r + 8'h01;
      end
    end
  end

  // calibration wave; rates are crystal-derived approximations of the nominal
  always_comb begin
    unique case (pincfg_r.cal_freq_select)
      2'b00: cal_half = `RWK_HALF_1HZ;
      2'b01: cal_half = `RWK_HALF_512HZ;
      2'b10: cal_half = `RWK_HALF_500HZ;
      2'b11: cal_half = `RWK_HALF_16KHZ;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_cnt_r <= 16'h0000;
      cal_wave_r <= 1'b0;
    end else if (!pincfg_r.cal_output_enable) begin
      cal_cnt_r <= 16'h0000;
      cal_wave_r <= 1'b0;
    end else if (rtc_tick) begin
      if (cal_cnt_r >= cal_half) begin
        cal_cnt_r <= 16'h0000;
        cal_wave_r <= ~cal_wave_r;
      end else begin
        cal_cnt_r <= cal_cnt_r + 16'h0001;
      end
    end
  end

  assign shared_cal_pin = cal_wave_r;
  assign shared_cal_pin_oe = pincfg_r.cal_output_enable;

  // interrupt pin functions
  always_comb begin
    if (pincfg_r.ext_irq_b_pin_function[2:1] == 2'b11) begin
      irqb_mode = RWK_IRQB_ON;
    end else if (pincfg_r.ext_irq_b_pin_function[2:1] == 2'b01) begin
      irqb_mode = RWK_IRQB_OFF;
    end else if (pincfg_r.ext_irq_b_pin_function[1:0] == 2'b01) begin
      irqb_mode = RWK_IRQB_BATT;
    end else begin
      irqb_mode = RWK_IRQB_GPIO;
    end
  end

  assign ext_irq_a_req = pincfg_r.ext_irq_a_pin_function && irqa_sync_r[1];
  assign ext_irq_b_req = (irqb_mode == RWK_IRQB_ON) && irqb_sync_r[1];
  assign battery_control_input = (irqb_mode == RWK_IRQB_BATT) && irqb_sync_r[1];
  assign ext_irq_b_gpio_in = (irqb_mode == RWK_IRQB_GPIO) && irqb_sync_r[1];

  always_comb begin
    unique case (sfr_addr)
      `RWK_ADDR_CONFIG: sfr_rdata = rtc_config_register;
      `RWK_ADDR_SUBSEC: sfr_rdata = sub_second_counter;
      `RWK_ADDR_SEC: sfr_rdata = sec_r;
      `RWK_ADDR_MIN: sfr_rdata = min_r;
      `RWK_ADDR_HOUR: sfr_rdata = hour_r;
      `RWK_ADDR_ALARM_INTERVAL_REGISTER: sfr_rdata = alarm_interval_register;
      `RWK_ADDR_KEY: sfr_rdata = write_key_register;
      `RWK_ADDR_PINCFG: sfr_rdata = pincfg_r;
      `RWK_ADDR_POWER: sfr_rdata = power_control_register;
      default: sfr_rdata = 8'h00;
    endcase
  end
endmodule

// [rwk_checker.sv]
`timescale 1ns/100ps
module rwk_checker
  import rwk_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // pins
  input wire logic ext_irq_a_in,
  input wire logic ext_irq_b_in,
  input wire logic shared_cal_pin,
  input wire logic shared_cal_pin_oe,
  input wire logic ext_irq_a_req,
  input wire logic ext_irq_b_req,
  input wire logic battery_control_input,
  input wire logic ext_irq_b_gpio_in,
  // rtc side
  input wire logic [7:0] power_control_register,
  input wire logic [7:0] rtc_config_q
);
  logic [7:0] key_m;
  logic [7:0] cfg_m;
  logic [11:0] cfg_age;
  logic spend;
  // unlock state rebuilt from bus traffic only
  assign spend = sfr_wr && ((key_m == 8'hea && sfr_addr inside {[8'ha2:8'ha5], 8'hff})
    || (key_m == 8'ha7 && sfr_addr == 8'hc5));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) key_m <= 8'h00;
    else if (sfr_wr && sfr_addr == 8'hc1) key_m <= sfr_wdata;
    else if (spend) key_m <= 8'h00;
  end
  // age assumes a crystal at a quarter of clk: two slow periods are 2048 clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_m <= 8'h00;
      cfg_age <= 12'h000;
    end else if (sfr_wr && sfr_addr == 8'ha1) begin
      cfg_m <= sfr_wdata;
      cfg_age <= 12'h000;
    end else if (cfg_age != 12'hfff) begin
      cfg_age <= cfg_age + 12'h001;
    end
  end
  sequence pins_quiet;
    (sfr_addr == 8'hff && !sfr_wr && $stable(ext_irq_a_in) && $stable(ext_irq_b_in)) [*4];
  endsequence
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_POWER_LOCK: assert property (sfr_wr && sfr_addr == 8'hc5 && key_m != 8'ha7
    |=> $stable(power_control_register)) else $error("locked power write taken");
  AST_POWER_OPEN: assert property (sfr_wr && sfr_addr == 8'hc5 && key_m == 8'ha7
    |=> power_control_register == $past(sfr_wdata)) else $error("power write lost");
  AST_TIME_LOCK: assert property (sfr_wr && sfr_addr == 8'ha5 && key_m != 8'hea
    ##1 sfr_addr == 8'ha5 |-> sfr_rdata == $past(sfr_rdata)) else $error("hour not locked");
  AST_TIME_OPEN: assert property (sfr_wr && sfr_addr == 8'ha5 && key_m == 8'hea
    ##1 sfr_addr == 8'ha5 |-> sfr_rdata == $past(sfr_wdata)) else $error("hour write lost");
  AST_KEY_MIRROR: assert property (sfr_addr == 8'hc1 |-> sfr_rdata == key_m)
    else $error("key state wrong");
  AST_CAL_OE: assert property ((sfr_addr == 8'hff && !sfr_wr) [*3]
    |-> shared_cal_pin_oe == sfr_rdata[7]) else $error("cal enable wrong");
  AST_CAL_QUIET: assert property (!shared_cal_pin_oe [*2] |-> !shared_cal_pin)
    else $error("cal pin moves while off");
  AST_IRQ_A: assert property (pins_quiet
    |-> ext_irq_a_req == (ext_irq_a_in && sfr_rdata[0])) else $error("irq a routing");
  AST_IRQ_B_ON: assert property (pins_quiet
    |-> ext_irq_b_req == (ext_irq_b_in && sfr_rdata[3:2] == 2'b11)) else $error("irq b routing");
  AST_IRQ_B_BATT: assert property (pins_quiet
    |-> battery_control_input == (ext_irq_b_in && sfr_rdata[2:1] == 2'b01)) else $error("batt");
  AST_IRQ_B_GPIO: assert property (pins_quiet
    |-> ext_irq_b_gpio_in == (ext_irq_b_in && sfr_rdata[2:1] == 2'b00)) else $error("gpio");
  AST_CFG_LATE: assert property (cfg_age == 12'd2100 |-> rtc_config_q == cfg_m)
    else $error("config transfer late");
  AST_CFG_SLOW: assert property (cfg_age == 12'd4
    |-> rtc_config_q == $past(rtc_config_q, 4)) else $error("config transfer early");
  cover property (spend);
  cover property (shared_cal_pin_oe && $rose(shared_cal_pin));
  cover property (cfg_age == 12'd2100);
endmodule

bind rwk_top rwk_checker chk (.clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_irq_a_in(ext_irq_a_in),
  .ext_irq_b_in(ext_irq_b_in), .shared_cal_pin(shared_cal_pin),
  .shared_cal_pin_oe(shared_cal_pin_oe), .ext_irq_a_req(ext_irq_a_req),
  .ext_irq_b_req(ext_irq_b_req), .battery_control_input(battery_control_input),
  .ext_irq_b_gpio_in(ext_irq_b_gpio_in), .power_control_register(power_control_register),
  .rtc_config_q(rtc_config_q));

// [test_rwk_top.sv]
`timescale 1ns/100ps
module test_rwk_top;
  import rwk_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rtc_xtal = 1'b0, sfr_wr = 1'b0;
  logic ext_irq_a_in = 1'b0, ext_irq_b_in = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata, power_control_register, rtc_config_q, alarm_interval_q;
  logic shared_cal_pin, shared_cal_pin_oe, ext_irq_a_req, ext_irq_b_req;
  logic battery_control_input, ext_irq_b_gpio_in;
  logic [3:0] e;
  int failures = 0, checks = 0, n, i;
  int cal_h [4] = '{255, 32, 33, 1};
  always #10 clk = ~clk;
  // crystal at a quarter of clk, so one 128 Hz period is 1024 clocks
  initial #3 forever #40 rtc_xtal = ~rtc_xtal;
  rwk_top uut (.clk(clk), .rst(rst), .rtc_xtal(rtc_xtal), .sfr_wr(sfr_wr),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .ext_irq_a_in(ext_irq_a_in), .ext_irq_b_in(ext_irq_b_in),
    .shared_cal_pin(shared_cal_pin), .shared_cal_pin_oe(shared_cal_pin_oe),
    .ext_irq_a_req(ext_irq_a_req), .ext_irq_b_req(ext_irq_b_req),
    .battery_control_input(battery_control_input), .ext_irq_b_gpio_in(ext_irq_b_gpio_in),
    .power_control_register(power_control_register), .rtc_config_q(rtc_config_q),
    .alarm_interval_q(alarm_interval_q));
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    #2 chk(what, exp, sfr_rdata);
  endtask
  task wk(input logic [7:0] a, input logic [7:0] d);
    wr(8'hc1, 8'hea);
    wr(a, d);
  endtask
  // half period of the cal wave in crystal ticks; 255 if it never toggles twice
  task meas(output int h);
    logic p;
    int k, t;
    p = shared_cal_pin;
    k = 0;
    t = 0;
    h = 255;
    repeat (400) begin
      @(posedge rtc_xtal);
      t++;
      if (shared_cal_pin !== p && k < 2) begin
        p = shared_cal_pin;
        k++;
        if (k == 2) h = t;
        t = 0;
      end
    end
  endtask
  task lat(input logic [7:0] a, input logic [7:0] d);
    int c;
    wr(a, d);
    repeat (3) @(negedge clk);
    chk("copy early", 8'h00, a == 8'ha1 ? rtc_config_q : alarm_interval_q);
    for (c = 0; c < 2100 && (a == 8'ha1 ? rtc_config_q : alarm_interval_q) !== d; c++)
      @(negedge clk);
    chk("copy", d, a == 8'ha1 ? rtc_config_q : alarm_interval_q);
  endtask
  task end_sim;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2000000;
    failures++;
    end_sim;
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rd("key rst", 8'hc1, 8'h00);
    rd("pincfg rst", 8'hff, 8'h00);
    wr(8'hc5, 8'h5a);
    wr(8'hc1, 8'hea);
    wr(8'hc5, 8'h33);
    rd("key kept", 8'hc1, 8'hea);
    chk("power locked", 8'h00, power_control_register);
    wr(8'hc1, 8'ha7);
    wr(8'hc5, 8'h3c);
    wr(8'hc5, 8'h55);
    chk("power", 8'h3c, power_control_register);
    rd("key spent", 8'hc1, 8'h00);
    wr(8'ha5, 8'h12);
    rd("hour locked", 8'ha5, 8'h00);
    wk(8'ha5, 8'h12);
    wr(8'ha5, 8'h34);
    rd("hour", 8'ha5, 8'h12);
    wk(8'ha4, 8'h3b);
    wr(8'hc1, 8'hea);
    wr(8'hc1, 8'h00);
    wr(8'ha4, 8'h01);
    rd("minute", 8'ha4, 8'h3b);
    ext_irq_a_in = 1'b1;
    ext_irq_b_in = 1'b1;
    for (i = 0; i < 16; i++) begin
      wk(8'hff, 8'(i));
      repeat (5) @(negedge clk);
      e = {i[0], i[3:2] == 2'b11, i[2:1] == 2'b01, i[2:1] == 2'b00};
      chk("irq", {4'h0, e}, {4'h0, ext_irq_a_req, ext_irq_b_req, battery_control_input,
        ext_irq_b_gpio_in});
    end
    ext_irq_a_in = 1'b0;
    ext_irq_b_in = 1'b0;
    repeat (5) @(negedge clk);
    chk("irq low", 8'h00, {4'h0, ext_irq_a_req, ext_irq_b_req, battery_control_input,
      ext_irq_b_gpio_in});
    // disable between codes so each divider starts from rest
    for (i = 0; i < 4; i++) begin
      wk(8'hff, 8'h00);
      repeat (3) @(negedge clk);
      chk("cal off", 8'h00, {6'h0, shared_cal_pin_oe, shared_cal_pin});
      wk(8'hff, {1'b1, 2'(i), 5'h00});
      meas(n);
      chk("cal half", 8'(cal_h[i]), 8'(n));
      chk("cal oe", 8'h01, {7'h0, shared_cal_pin_oe});
    end
    lat(8'ha1, 8'h5a);
    lat(8'ha6, 8'h2c);
    rd("config rd", 8'ha1, 8'h5a);
    rd("interval rd", 8'ha6, 8'h2c);
    wk(8'ha3, 8'h05);
    wk(8'ha2, 8'h7f);
    for (n = 0; n < 1100 && sfr_rdata !== 8'h00; n++)
      @(negedge clk);
    chk("subsec wrap", 8'h00, sfr_rdata);
    rd("sec carry", 8'ha3, 8'h06);
    end_sim;
  end
endmodule
